// *** design/apsm_defines.svh ***
// Constants for the peak, strap and modulator control slice.
// Assumes inclusion by bare name from design files.
`ifndef APSM_DEFINES_SVH
`define APSM_DEFINES_SVH
// ----------------------------------------------------------------
// Register layout
// ----------------------------------------------------------------
`define APSM_ADDR_PEAK_L 4'h3
`define APSM_ADDR_PEAK_R 4'h4
`define APSM_ADDR_CTRL1 4'h0
`define APSM_ADDR_CTRL2 4'h1
`define APSM_ADDR_CTRL3 4'h2
`define APSM_CTRL1_PEAK_EN 8
`define APSM_CTRL1_MOD_EN 9
`define APSM_CTRL2_ROLE 5
`define APSM_CTRL2_FMT_LO 6
`define APSM_CTRL2_RATIO 8
`define APSM_CTRL3_SE_L 5
`define APSM_CTRL3_SE_R 4
`define APSM_CTRL3_DIS_L 3
`define APSM_CTRL3_SEL_L 2
`define APSM_CTRL3_DIS_R 1
`define APSM_CTRL3_SEL_R 0
`define APSM_CTRL_RESET 10'h000
`define APSM_PEAK_QUIET 6'h3F
`define APSM_WORD_BITS 16
`endif

// *** design/apsm_pkg.sv ***
// Types for the peak, strap and modulator control slice.
// Assumes the defines header is compiled alongside.
package apsm_pkg;
  typedef enum logic [1:0] {
    APSM_IDLE = 2'b00,
    APSM_SHIFT = 2'b01,
    APSM_DONE = 2'b10
  } apsm_port_e;
  typedef logic [5:0] apsm_peak_t;
endpackage

// *** design/apsm_sync.sv ***
// Two-flop synchroniser for pin levels.
// Assumes asynchronous active-low reset.
`timescale 1ns/1ps
module apsm_sync
  import apsm_pkg::*;
#(
  parameter int W = 1
)(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
  assign sync_out = sync_q;
endmodule // apsm_sync

// *** design/apsm_peak.sv ***
// One channel peak tracker with clear on read.
// Assumes conversion codes arrive on clk_sys as attenuation steps.
`timescale 1ns/1ps
`include "apsm_defines.svh"
module apsm_peak
  import apsm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic capture_en,
  input wire logic conv_valid,
  input wire apsm_peak_t conv_code,
  input wire logic read_clear,
  output apsm_peak_t peak_code
);
  apsm_peak_t peak_q;
  apsm_peak_t peak_d;
  logic fresh_q;
  logic fresh_d;
  // First conversion after a read restarts tracking
  always_comb
  begin
    peak_d = peak_q;
    fresh_d = fresh_q;
    if (read_clear)
    begin
      peak_d = 6'h00;
      fresh_d = 1'b1;
    end
    else if (capture_en && conv_valid && (fresh_q || (conv_code < peak_q)))
    begin
      peak_d = conv_code;
      fresh_d = 1'b0;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      peak_q <= `APSM_PEAK_QUIET;
      fresh_q <= 1'b0;
    end
    else
    begin
      peak_q <= peak_d;
      fresh_q <= fresh_d;
    end
  end
  assign peak_code = peak_q;
endmodule // apsm_peak

// *** design/apsm_ctrl.sv ***
// Control slice: serial control port, peak readback, straps, modulator output.
// Assumes conversion results and modulator bits on clk_sys; serial
// control clock pin is its own domain.
`timescale 1ns/1ps
`include "apsm_defines.svh"
module apsm_ctrl
  import apsm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic control_serial_clock_pin,
  input wire logic control_latch_pin,
  input wire logic control_serial_in_pin,
  output logic control_serial_out_pin,
  output logic control_serial_out_oe_n,
  input wire logic pin_strap_control_select,
  input wire logic format_strap_low,
  input wire logic conv_valid_l,
  input wire logic [5:0] conv_code_l,
  input wire logic conv_valid_r,
  input wire logic [5:0] conv_code_r,
  input wire logic mod_bit_valid,
  input wire logic [3:0] mod_data_l,
  input wire logic [3:0] mod_data_r,
  output logic [3:0] mod_data_out,
  output logic mod_data_oe_n,
  output logic clk_role_master,
  output logic frame_clk_oe_n,
  output logic bit_clk_oe_n,
  output logic ratio_512,
  output logic [1:0] serial_format_field,
  output logic left_input_stage_disable,
  output logic right_input_stage_disable,
  output logic left_input_pin_select,
  output logic right_input_pin_select,
  output logic left_single_ended_enable,
  output logic right_single_ended_enable
);
  // ----------------------------------------------------------------
  // Link side: shift words on the control clock
  // ----------------------------------------------------------------
  logic [`APSM_WORD_BITS-1:0] lk_shift_q;
  logic [`APSM_WORD_BITS-1:0] lk_shift_d;
  logic [4:0] lk_cnt_q;
  logic [4:0] lk_cnt_d;
  logic [`APSM_WORD_BITS-1:0] lk_word_q;
  logic [`APSM_WORD_BITS-1:0] lk_word_d;
  logic lk_tog_q;
  logic lk_tog_d;
  logic [9:0] lk_rd_q;
  logic [9:0] lk_rd_d;
  logic [9:0] rd_word_q;
  always_comb
  begin
    lk_shift_d = {lk_shift_q[`APSM_WORD_BITS-2:0], control_serial_in_pin};
    lk_cnt_d = lk_cnt_q;
    lk_word_d = lk_word_q;
    lk_tog_d = lk_tog_q;
    lk_rd_d = {lk_rd_q[8:0], 1'b0};
    if (control_latch_pin)
    begin
      lk_cnt_d = 5'h00;
    end
    else
    begin
      lk_cnt_d = (lk_cnt_q == 5'h0F) ? 5'h00 : lk_cnt_q + 5'h01;
      if (lk_cnt_q == 5'h05)
      begin
        lk_rd_d = rd_word_q;
      end
      if (lk_cnt_q == 5'h0F)
      begin
        lk_word_d = lk_shift_d;
        lk_tog_d = ~lk_tog_q;
      end
    end
  end
  always_ff @(posedge control_serial_clock_pin or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lk_shift_q <= '0;
      lk_cnt_q <= 5'h00;
      lk_word_q <= '0;
      lk_tog_q <= 1'b0;
      lk_rd_q <= 10'h000;
    end
    else
    begin
      lk_shift_q <= lk_shift_d;
      lk_cnt_q <= lk_cnt_d;
      lk_word_q <= lk_word_d;
      lk_tog_q <= lk_tog_d;
      lk_rd_q <= lk_rd_d;
    end
  end
  // ----------------------------------------------------------------
  // Crossing into the system clock
  // ----------------------------------------------------------------
  logic tog_s;
  logic tog_seen_q;
  logic [2:0] straps_s;
  logic xsel_s;
  logic fmt_lo_s;
  apsm_sync #(.W(1)) u_tog_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in(lk_tog_q),
    .sync_out(tog_s)
  );
  apsm_sync #(.W(5)) u_strap_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in({pin_strap_control_select, control_latch_pin,
      control_serial_clock_pin, control_serial_in_pin, format_strap_low}),
    .sync_out({xsel_s, straps_s, fmt_lo_s})
  );
  logic word_evt;
  assign word_evt = tog_s ^ tog_seen_q;
  // ----------------------------------------------------------------
  // Control words and peak readback
  // ----------------------------------------------------------------
  logic [9:0] ctrl1_q;
  logic [9:0] ctrl1_d;
  logic [9:0] ctrl2_q;
  logic [9:0] ctrl2_d;
  logic [9:0] ctrl3_q;
  logic [9:0] ctrl3_d;
  logic [9:0] rd_word_d;
  logic clr_l;
  logic clr_r;
  logic strap_fmt_lo_q;
  logic strap_fmt_lo_d;
  apsm_peak_t peak_l;
  apsm_peak_t peak_r;
  logic [3:0] w_addr;
  logic w_read;
  assign w_addr = lk_word_q[15:12];
  assign w_read = lk_word_q[11];
  always_comb
  begin
    ctrl1_d = ctrl1_q;
    ctrl2_d = ctrl2_q;
    ctrl3_d = ctrl3_q;
    rd_word_d = rd_word_q;
    clr_l = 1'b0;
    clr_r = 1'b0;
    strap_fmt_lo_d = strap_fmt_lo_q;
    if (word_evt && !xsel_s)
    begin
      if (w_read)
      begin
        if (w_addr == `APSM_ADDR_PEAK_L)
        begin
          rd_word_d = {4'h0, peak_l};
          clr_l = 1'b1;
        end
        else if (w_addr == `APSM_ADDR_PEAK_R)
        begin
          rd_word_d = {4'h0, peak_r};
          clr_r = 1'b1;
        end
        else
        begin
          rd_word_d = 10'h000;
        end
      end
      else
      begin
        unique case (w_addr)
          `APSM_ADDR_CTRL1: ctrl1_d = lk_word_q[9:0];
          `APSM_ADDR_CTRL2: ctrl2_d = lk_word_q[9:0];
          `APSM_ADDR_CTRL3: ctrl3_d = lk_word_q[9:0];
          default: ctrl1_d = ctrl1_q;
        endcase
      end
    end
    if (xsel_s)
    begin
      ctrl1_d = `APSM_CTRL_RESET;
      ctrl2_d = `APSM_CTRL_RESET;
      ctrl3_d = `APSM_CTRL_RESET;
      strap_fmt_lo_d = fmt_lo_s;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl1_q <= `APSM_CTRL_RESET;
      ctrl2_q <= `APSM_CTRL_RESET;
      ctrl3_q <= `APSM_CTRL_RESET;
      rd_word_q <= 10'h000;
      tog_seen_q <= 1'b0;
      strap_fmt_lo_q <= 1'b0;
    end
    else
    begin
      ctrl1_q <= ctrl1_d;
      ctrl2_q <= ctrl2_d;
      ctrl3_q <= ctrl3_d;
      rd_word_q <= rd_word_d;
      tog_seen_q <= tog_s;
      strap_fmt_lo_q <= strap_fmt_lo_d;
    end
  end
  // ----------------------------------------------------------------
  // Peak trackers
  // ----------------------------------------------------------------
  logic peak_en;
  assign peak_en = ctrl1_q[`APSM_CTRL1_PEAK_EN];
  apsm_peak u_peak_l (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .capture_en(peak_en),
    .conv_valid(conv_valid_l),
    .conv_code(conv_code_l),
    .read_clear(clr_l),
    .peak_code(peak_l)
  );
  apsm_peak u_peak_r (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .capture_en(peak_en),
    .conv_valid(conv_valid_r),
    .conv_code(conv_code_r),
    .read_clear(clr_r),
    .peak_code(peak_r)
  );
  // ----------------------------------------------------------------
  // Role, ratio and format selects
  // ----------------------------------------------------------------
  logic master_d;
  logic ratio_d;
  logic [1:0] fmt_d;
  always_comb
  begin
    if (xsel_s)
    begin
      master_d = ~straps_s[2];
      ratio_d = straps_s[1];
      fmt_d = {straps_s[0], strap_fmt_lo_q};
    end
    else
    begin
      master_d = ~ctrl2_q[`APSM_CTRL2_ROLE];
      ratio_d = ctrl2_q[`APSM_CTRL2_RATIO];
      fmt_d = ctrl2_q[`APSM_CTRL2_FMT_LO +: 2];
    end
  end
  // ----------------------------------------------------------------
  // Modulator output mode
  // ----------------------------------------------------------------
  logic mod_en;
  logic modulator_sample_clock_q;
  logic modulator_sample_clock_d;
  logic [3:0] mod_out_q;
  logic [3:0] mod_out_d;
  logic [3:0] hold_r_q;
  logic [3:0] hold_r_d;
  logic serial_out_q;
  logic serial_out_d;
  assign mod_en = ctrl1_q[`APSM_CTRL1_MOD_EN] && !xsel_s;
  always_comb
  begin
    modulator_sample_clock_d = 1'b0;
    mod_out_d = mod_out_q;
    hold_r_d = hold_r_q;
    if (mod_en && mod_bit_valid)
    begin
      modulator_sample_clock_d = 1'b0;
      mod_out_d = mod_data_l;
      hold_r_d = mod_data_r;
    end
    else if (mod_en && !modulator_sample_clock_q)
    begin
      modulator_sample_clock_d = 1'b1;
      mod_out_d = hold_r_q;
    end
    else if (mod_en)
    begin
      modulator_sample_clock_d = modulator_sample_clock_q;
    end
    serial_out_d = modulator_sample_clock_d;
  end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      modulator_sample_clock_q <= 1'b0;
      mod_out_q <= 4'h0;
      hold_r_q <= 4'h0;
      serial_out_q <= 1'b0;
      clk_role_master <= 1'b1;
      ratio_512 <= 1'b0;
      serial_format_field <= 2'h0;
    end
    else
    begin
      modulator_sample_clock_q <= modulator_sample_clock_d;
      mod_out_q <= mod_out_d;
      hold_r_q <= hold_r_d;
      serial_out_q <= serial_out_d;
      clk_role_master <= master_d;
      ratio_512 <= ratio_d;
      serial_format_field <= fmt_d;
    end
  end
  // Readback bits leave straight from the link-clock shifter
  assign control_serial_out_pin = mod_en ? serial_out_q : lk_rd_q[9];
  assign control_serial_out_oe_n = xsel_s;
  assign mod_data_out = mod_out_q;
  assign mod_data_oe_n = ~mod_en;
  assign frame_clk_oe_n = ~clk_role_master;
  assign bit_clk_oe_n = ~clk_role_master;
  assign left_input_stage_disable = ctrl3_q[`APSM_CTRL3_DIS_L];
  assign right_input_stage_disable = ctrl3_q[`APSM_CTRL3_DIS_R];
  assign left_input_pin_select = ctrl3_q[`APSM_CTRL3_SEL_L] & ctrl3_q[`APSM_CTRL3_SE_L];
  assign right_input_pin_select = ctrl3_q[`APSM_CTRL3_SEL_R] & ctrl3_q[`APSM_CTRL3_SE_R];
  assign left_single_ended_enable = ctrl3_q[`APSM_CTRL3_SE_L];
  assign right_single_ended_enable = ctrl3_q[`APSM_CTRL3_SE_R];
endmodule // apsm_ctrl

// *** verif/apsm_ctrl_monitor.sv ***
// Concurrent checks on the control slice top ports.
// Assumes binding to apsm_ctrl, clk_sys domain only.
`timescale 1ns/1ps
module apsm_ctrl_monitor
  import apsm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic control_latch_pin,
  input wire logic control_serial_clock_pin,
  input wire logic control_serial_in_pin,
  input wire logic control_serial_out_pin,
  input wire logic pin_strap_control_select,
  input wire logic format_strap_low,
  input wire logic [3:0] mod_data_l,
  input wire logic [3:0] mod_data_r,
  input wire logic [3:0] mod_data_out,
  input wire logic mod_data_oe_n,
  input wire logic clk_role_master,
  input wire logic frame_clk_oe_n,
  input wire logic bit_clk_oe_n,
  input wire logic ratio_512,
  input wire logic [1:0] serial_format_field,
  input wire logic left_input_stage_disable,
  input wire logic right_input_stage_disable
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence s_strap;
    (pin_strap_control_select && $stable({control_latch_pin, format_strap_low,
      control_serial_clock_pin, control_serial_in_pin}))[*6];
  endsequence
  sequence s_mod;
    (!mod_data_oe_n && $stable({mod_data_l, mod_data_r}))[*8];
  endsequence
  sequence s_idle;
    (control_latch_pin && !pin_strap_control_select)[*8];
  endsequence
  AST_MASTER_OE: assert property (
    clk_role_master |-> !(frame_clk_oe_n | bit_clk_oe_n)) else $error("master clocks off");
  AST_SLAVE_OE: assert property (
    !clk_role_master |-> frame_clk_oe_n && bit_clk_oe_n) else $error("slave drives clocks");
  AST_STRAP_ROLE: assert property (
    s_strap |-> clk_role_master == !control_latch_pin) else $error("role strap");
  AST_STRAP_RATIO: assert property (
    s_strap |-> ratio_512 == control_serial_clock_pin) else $error("ratio strap");
  AST_STRAP_FMT: assert property (
    s_strap |-> serial_format_field == {control_serial_in_pin, format_strap_low})
    else $error("format strap");
  AST_STRAP_DEFAULT: assert property (
    s_strap |-> mod_data_oe_n && !left_input_stage_disable && !right_input_stage_disable)
    else $error("strap defaults");
  AST_RESET_DEFAULT: assert property (
    $rose(rst_n) |-> clk_role_master && mod_data_oe_n && !ratio_512)
    else $error("reset defaults");
  AST_MOD_LEFT: assert property (
    s_mod ##0 !control_serial_out_pin |-> mod_data_out == mod_data_l) else $error("left phase");
  AST_MOD_RIGHT: assert property (
    s_mod ##0 control_serial_out_pin |-> mod_data_out == mod_data_r) else $error("right phase");
  AST_STANDS: assert property (
    s_idle |-> $stable({clk_role_master, ratio_512, serial_format_field,
      left_input_stage_disable, right_input_stage_disable})) else $error("setting moved");
endmodule // apsm_ctrl_monitor

bind apsm_ctrl apsm_ctrl_monitor mon (.clk_sys, .rst_n, .control_latch_pin,
  .control_serial_clock_pin, .control_serial_in_pin, .control_serial_out_pin,
  .pin_strap_control_select, .format_strap_low, .mod_data_l, .mod_data_r,
  .mod_data_out, .mod_data_oe_n,
  .clk_role_master, .frame_clk_oe_n, .bit_clk_oe_n, .ratio_512, .serial_format_field,
  .left_input_stage_disable, .right_input_stage_disable);

// *** verif/apsm_host_model.sv ***
// Serial control host and strap driver.
// Assumes 15 ns link clock, running only inside frames.
`timescale 1ns/1ps
module apsm_host_model (
  output logic control_serial_clock_pin,
  output logic control_latch_pin,
  output logic control_serial_in_pin,
  input wire logic control_serial_out_pin
);
  task automatic strap(input logic l, input logic c, input logic d);
    control_latch_pin = l;
    control_serial_clock_pin = c;
    control_serial_in_pin = d;
  endtask
  task automatic frame(input logic [15:0] w, output logic [9:0] rd);
    rd = 10'h000;
    control_latch_pin = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      control_serial_in_pin = w[i];
      #7.5 control_serial_clock_pin = 1'b1;
      #7.5 control_serial_clock_pin = 1'b0;
      if (i < 11 && i > 0)
        rd = {rd[8:0], control_serial_out_pin};
    end
    control_latch_pin = 1'b1;
    control_serial_in_pin = ~w[0];
    #400;
  endtask
  initial strap(1'b1, 1'b0, 1'b0);
endmodule // apsm_host_model

// *** verif/apsm_ctrl_tb_top.sv ***
// Self-checking bench for the control slice.
// Assumes host model drives the serial pins, also as straps; the bench drives the strap select and format strap.
`timescale 1ns/1ps
module apsm_ctrl_tb_top;
  import apsm_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic pin_strap_control_select = 1'b0;
  logic control_serial_clock_pin, control_latch_pin, control_serial_in_pin;
  logic control_serial_out_pin, mod_data_oe_n, clk_role_master, frame_clk_oe_n;
  logic bit_clk_oe_n, ratio_512, left_input_stage_disable, right_input_stage_disable;
  logic control_serial_out_oe_n;
  logic format_strap_low = 1'b0;
  logic left_input_pin_select, right_input_pin_select;
  logic left_single_ended_enable, right_single_ended_enable;
  logic [1:0] serial_format_field;
  logic [3:0] mod_data_out;
  logic conv_valid_l = 1'b0, conv_valid_r = 1'b0, mod_bit_valid = 1'b0;
  logic [5:0] conv_code_l = 6'h00, conv_code_r = 6'h00;
  logic [3:0] mod_data_l = 4'hA, mod_data_r = 4'h5;
  logic [9:0] rd;
  logic [1:0] hl;
  logic [5:0] p3 [4] = '{6'h0A, 6'h24, 6'h11, 6'h00};
  int n_errors = 0, cmp_count = 0;
  wire [9:0] cfg = {4'h0, clk_role_master, frame_clk_oe_n, bit_clk_oe_n, ratio_512,
    serial_format_field};
  wire [5:0] c3 = {left_single_ended_enable, right_single_ended_enable,
    left_input_stage_disable, left_input_pin_select, right_input_stage_disable,
    right_input_pin_select};
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) mod_bit_valid <= ~mod_bit_valid;
  apsm_ctrl uut (.clk_sys, .rst_n, .control_serial_clock_pin, .control_latch_pin,
    .control_serial_in_pin, .control_serial_out_pin, .pin_strap_control_select,
    .control_serial_out_oe_n, .format_strap_low,
    .conv_valid_l, .conv_code_l, .conv_valid_r, .conv_code_r, .mod_bit_valid,
    .mod_data_l, .mod_data_r, .mod_data_out, .mod_data_oe_n, .clk_role_master,
    .frame_clk_oe_n, .bit_clk_oe_n, .ratio_512, .serial_format_field,
    .left_input_stage_disable, .right_input_stage_disable, .left_input_pin_select,
    .right_input_pin_select, .left_single_ended_enable, .right_single_ended_enable);
  apsm_host_model host (.control_serial_clock_pin, .control_latch_pin,
    .control_serial_in_pin, .control_serial_out_pin);
  // ----
  // Tasks
  // ----
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    if (n_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [3:0] a, input logic [9:0] d);
    host.frame({a, 2'b00, d}, rd);
    cyc(8);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [5:0] e);
    host.frame({a, 2'b10, 10'h000}, rd);
    chk(rd, {4'h0, e});
  endtask
  task automatic conv(input logic r, input logic [5:0] c);
    @(posedge clk_sys);
    conv_valid_l <= !r;
    conv_valid_r <= r;
    conv_code_l <= c;
    conv_code_r <= c;
    @(posedge clk_sys);
    conv_valid_l <= 1'b0;
    conv_valid_r <= 1'b0;
  endtask
  // ----
  // Sequence
  // ----
  initial
  begin
    cyc(3);
    rst_n <= 1'b1;
    cyc(3);
    chk(cfg, 10'h020);
    chk({2'h0, control_serial_out_oe_n, mod_data_oe_n, c3}, 10'h040);
    conv(1'b0, 6'h05);
    conv(1'b1, 6'h05);
    wr(4'h0, 10'h100);
    conv(1'b0, 6'h14);
    conv(1'b0, 6'h0A);
    conv(1'b0, 6'h1E);
    conv(1'b1, 6'h07);
    host.frame({4'h3, 2'b10, 10'h000}, rd);
    rdc(4'h4, 6'h0A);
    rdc(4'h3, 6'h07);
    conv(1'b0, 6'h20);
    rdc(4'h5, 6'h00);
    rdc(4'h3, 6'h00);
    rdc(4'h5, 6'h20);
    foreach (p3[i])
    begin
      wr(4'h2, {4'h0, p3[i]});
      chk({4'h0, c3}, {4'h0, p3[i]});
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(4'h1, {1'b0, i[0], i[1:0], i[1], 5'h00});
      chk(cfg, {4'h0, !i[1], i[1], i[1], i[0], i[1:0]});
    end
    wr(4'h0, 10'h200);
    hl = 2'b00;
    repeat (32)
    begin
      @(negedge clk_sys);
      hl |= {control_serial_out_pin, !control_serial_out_pin};
      chk({5'h00, mod_data_oe_n, mod_data_out},
        control_serial_out_pin ? 10'h005 : 10'h00A);
    end
    chk({8'h00, hl}, 10'h003);
    wr(4'h0, 10'h000);
    wr(4'h2, 10'h03F);
    pin_strap_control_select <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      host.strap(i[0], i[1], i[0] ^ i[1]);
      format_strap_low <= i[0];
      cyc(8);
      chk(cfg, {4'h0, !i[0], i[0], i[0], i[1], i[0] ^ i[1], i[0]});
      chk({2'h0, control_serial_out_oe_n, mod_data_oe_n, c3}, 10'h0C0);
    end
    finish_test();
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    finish_test();
  end
endmodule // apsm_ctrl_tb_top
